// file: etsb_regs.svh
`ifndef ETSB_REGS_SVH
`define ETSB_REGS_SVH

// Register indices; byte address is four times the index
`define ETSB_IDX_EV_EN      8'h20
`define ETSB_IDX_EV1_CFG    8'h21
`define ETSB_IDX_FLT1       8'h22
`define ETSB_IDX_EV2_CFG    8'h23
`define ETSB_IDX_FLT2       8'h24
`define ETSB_IDX_BUF_CFG1   8'h27
`define ETSB_IDX_BUF_STAT   8'h28
`define ETSB_IDX_BUF_CFG2   8'h29
`define ETSB_IDX_CMD_CFG    8'h2A
`define ETSB_IDX_CMD_TRG    8'h2B
`define ETSB_IDX_IRQ_STAT   8'h2C
`define ETSB_IDX_IRQ_MASK   8'h2D
`define ETSB_IDX_BANK0      8'h40
`define ETSB_IDX_BANK7      8'h47

// Field positions
`define ETSB_EN_CP2_BIT     4
`define ETSB_EN_CP1_BIT     3
`define ETSB_EN_EV2_BIT     1
`define ETSB_EN_EV1_BIT     0
`define ETSB_CFG1_SEL_BIT   7
`define ETSB_CFG1_OVW_BIT   6
`define ETSB_CFG1_FIE_BIT   2
`define ETSB_CFG1_EIE_BIT   1
`define ETSB_CFG1_OIE_BIT   0
`define ETSB_STAT_FULL_BIT  7
`define ETSB_STAT_EMPTY_BIT 6
`define ETSB_STAT_OVW_BIT   0
`define ETSB_CFG2_SRAM_BIT  6
`define ETSB_CMD_CLR_BIT    0
`define ETSB_IRQ_FULL_BIT   2
`define ETSB_IRQ_NE_BIT     1
`define ETSB_IRQ_OVW_BIT    0

// Codes and reset values
`define ETSB_POL_FALL       2'h0
`define ETSB_POL_RISE       2'h1
`define ETSB_POL_RST        2'h0
`define ETSB_FLT_RST        6'h00
`define ETSB_FLT_MS_MODE    6'h00
`define ETSB_STAT_RST       8'h40
`define ETSB_LAST_BANK      3'h7
`define ETSB_BANKS          4'h8
`define ETSB_RESP_OKAY      2'h0
`define ETSB_RESP_SLVERR    2'h2

// Timing
`define ETSB_CLK_MHZ        250
`define ETSB_GRID_MS        125
`define ETSB_MIN_PULSE_MS   1

`endif

// file: etsb_pkg.sv
package etsb_pkg;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        level;
    logic [31:0] ms_cnt;
    logic [5:0]  grid_cnt;
    logic        rise;
    logic        fall;
  } etsb_flt_t;

  typedef struct packed {
    logic [5:0]       flt1;
    logic [5:0]       flt2;
    logic [1:0]       pol1;
    logic [1:0]       pol2;
    logic [1:0]       ev_en;
    logic [1:0]       cp_en;
    logic             src_bin;
    logic             ovw_mode;
    logic             full_ie;
    logic             ne_ie;
    logic             ovw_ie;
    logic             sram;
    logic             clr_en;
    logic             full;
    logic             empty;
    logic             overwrite_flag;
    logic [3:0]       wr_ptr;
    logic [7:0][31:0] banks;
    logic [2:0]       irq_st;
    logic [2:0]       irq_mask;
    logic [31:0]      grid_cnt;
    logic             tick;
    logic             irq;
    logic             aw_got;
    logic [11:0]      awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } etsb_state_t;

endpackage : etsb_pkg

// file: etsb_filter.sv
`timescale 1ns/1ns
`include "etsb_regs.svh"

module etsb_filter #(
  parameter int unsigned MS_CYCLES = 250000
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Pin and timing
  input  wire logic       pin,
  input  wire logic       tick,
  input  wire logic [5:0] setting,
  // Accepted edges
  output logic            rise,
  output logic            fall
);

  etsb_pkg::etsb_flt_t r;
  etsb_pkg::etsb_flt_t n;

  always_comb begin
    n = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (setting == `ETSB_FLT_MS_MODE) begin
      // Level must hold the short minimum time
      n.grid_cnt = 6'h00;
      if (r.s2 != r.level) begin
        if (r.ms_cnt + 32'h1 >= MS_CYCLES) begin
          n.level = r.s2;
          n.ms_cnt = 32'h0;
          n.rise = r.s2;
          n.fall = ~r.s2;
        end else begin
          n.ms_cnt = r.ms_cnt + 32'h1;
        end
      end else begin
        n.ms_cnt = 32'h0;
      end
    end else begin
      // N equal grid samples accept the new level
      n.ms_cnt = 32'h0;
      if (tick) begin
        if (r.s2 != r.level) begin
          if (r.grid_cnt + 6'h1 >= setting) begin
            n.level = r.s2;
            n.grid_cnt = 6'h00;
            n.rise = r.s2;
            n.fall = ~r.s2;
          end else begin
            n.grid_cnt = r.grid_cnt + 6'h1;
          end
        end else begin
          n.grid_cnt = 6'h00;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.level <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rise = r.rise;
  assign fall = r.fall;

endmodule : etsb_filter

// file: etsb_top.sv
// Functional notes
// [R01] Each event channel has its own six-bit filter time register.
// [R02] Filter samples on 125 ms grid; N grid samples; zero means 1 ms.
// [R03] Software never writes filter value 0x01 or 0x29 and above.
// [R04] Source select: 1 captures binary counter, 0 captures BCD counter.
// [R05] Overwrite mode replaces last bank when full; inhibit discards captures.
// [R06] Full interrupt enable sets full event flag when buffer becomes full.
// [R07] Not-empty enable sets flag when data enters an empty buffer.
// [R08] Overwrite enable sets flag on capture while buffer full.
// [R09] Full flag rises when last bank is written; zero while space remains.
// [R10] Empty flag is one after reset, cleared by first capture.
// [R11] Overwrite flag rises on any capture while buffer full.
// [R12] Buffer reads never clear flags; clear enable plus command trigger does.
// [R13] Plain memory mode makes the buffer ordinary read/write storage.
// [R14] Captures fill banks in order; last bank is final slot.
// [R15] Capture enable works only while event input enable is set.
// [R16] Polarity: 00 falling, 01 rising, other codes both edges.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "etsb_regs.svh"

module etsb_top #(
  parameter int unsigned GRID_CYCLES = `ETSB_GRID_MS * 1000 * `ETSB_CLK_MHZ,
  parameter int unsigned MS_CYCLES   = `ETSB_MIN_PULSE_MS * 1000 * `ETSB_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event pins and time counters
  input  wire logic [1:0]  event_input_pin,
  input  wire logic [31:0] bcd_time_data,
  input  wire logic [31:0] bin_time_data,
  // Interrupt
  output logic             irq
);

  etsb_pkg::etsb_state_t r;
  etsb_pkg::etsb_state_t n;

  logic [1:0] flt_rise;
  logic [1:0] flt_fall;
  logic [5:0] flt_set [2];
  logic [1:0] pol_sel [2];
  logic [1:0] chan_hit;

  function automatic logic [7:0] etsb_index(input logic [11:0] addr);
    etsb_index = addr[9:2];
  endfunction : etsb_index

  function automatic logic etsb_is_bank(input logic [7:0] idx);
    etsb_is_bank = (idx >= `ETSB_IDX_BANK0) && (idx <= `ETSB_IDX_BANK7);
  endfunction : etsb_is_bank

  function automatic logic etsb_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    etsb_mapped = 1'b0;
    if (addr[11:10] == 2'h0) begin
      case (idx)
        `ETSB_IDX_EV_EN,
        `ETSB_IDX_EV1_CFG,
        `ETSB_IDX_FLT1,
        `ETSB_IDX_EV2_CFG,
        `ETSB_IDX_FLT2,
        `ETSB_IDX_BUF_CFG1,
        `ETSB_IDX_BUF_STAT,
        `ETSB_IDX_BUF_CFG2,
        `ETSB_IDX_CMD_CFG,
        `ETSB_IDX_CMD_TRG,
        `ETSB_IDX_IRQ_STAT,
        `ETSB_IDX_IRQ_MASK: etsb_mapped = 1'b1;
        default:            etsb_mapped = etsb_is_bank(idx);
      endcase
    end
  endfunction : etsb_mapped

  // Byte lanes enabled by the write strobes
  function automatic logic [31:0] etsb_strobe_mask(input logic [3:0] strb);
    etsb_strobe_mask = 32'h0;
    for (int b = 0; b < 4; b++) begin
      etsb_strobe_mask[b*8 +: 8] = {8{strb[b]}};
    end
  endfunction : etsb_strobe_mask

  // Register read value; reads never change state
  function automatic logic [31:0] etsb_read_word(input etsb_pkg::etsb_state_t s,
                                                 input logic [7:0]            idx);
    etsb_read_word = 32'h0;
    case (idx)
      `ETSB_IDX_EV_EN: begin
        etsb_read_word[`ETSB_EN_CP2_BIT] = s.cp_en[1];
        etsb_read_word[`ETSB_EN_CP1_BIT] = s.cp_en[0];
        etsb_read_word[`ETSB_EN_EV2_BIT] = s.ev_en[1];
        etsb_read_word[`ETSB_EN_EV1_BIT] = s.ev_en[0];
      end
      `ETSB_IDX_EV1_CFG:  etsb_read_word[1:0] = s.pol1;
      `ETSB_IDX_EV2_CFG:  etsb_read_word[1:0] = s.pol2;
      `ETSB_IDX_FLT1:     etsb_read_word[5:0] = s.flt1;
      `ETSB_IDX_FLT2:     etsb_read_word[5:0] = s.flt2;
      `ETSB_IDX_BUF_CFG1: begin
        etsb_read_word[`ETSB_CFG1_SEL_BIT] = s.src_bin;
        etsb_read_word[`ETSB_CFG1_OVW_BIT] = s.ovw_mode;
        etsb_read_word[`ETSB_CFG1_FIE_BIT] = s.full_ie;
        etsb_read_word[`ETSB_CFG1_EIE_BIT] = s.ne_ie;
        etsb_read_word[`ETSB_CFG1_OIE_BIT] = s.ovw_ie;
      end
      `ETSB_IDX_BUF_STAT: begin
        etsb_read_word[`ETSB_STAT_FULL_BIT]  = s.full;
        etsb_read_word[`ETSB_STAT_EMPTY_BIT] = s.empty;
        etsb_read_word[`ETSB_STAT_OVW_BIT]   = s.overwrite_flag;
      end
      `ETSB_IDX_BUF_CFG2: etsb_read_word[`ETSB_CFG2_SRAM_BIT] = s.sram;
      `ETSB_IDX_CMD_CFG:  etsb_read_word[`ETSB_CMD_CLR_BIT] = s.clr_en;
      `ETSB_IDX_CMD_TRG:  etsb_read_word = 32'h0;
      `ETSB_IDX_IRQ_STAT: etsb_read_word[2:0] = s.irq_st;
      `ETSB_IDX_IRQ_MASK: etsb_read_word[2:0] = s.irq_mask;
      default:            etsb_read_word = etsb_is_bank(idx) ? s.banks[idx[2:0]] : 32'h0;
    endcase
  endfunction : etsb_read_word

  // Edge selection for one channel
  function automatic logic etsb_edge_hit(input logic [1:0] edge_polarity,
                                         input logic       rise,
                                         input logic       fall);
    case (edge_polarity)
      `ETSB_POL_FALL: etsb_edge_hit = fall;
      `ETSB_POL_RISE: etsb_edge_hit = rise;
      default:        etsb_edge_hit = rise | fall;
    endcase
  endfunction : etsb_edge_hit

  // Per-channel settings indexed by channel
  assign flt_set[0] = r.flt1;
  assign flt_set[1] = r.flt2;
  assign pol_sel[0] = r.pol1;
  assign pol_sel[1] = r.pol2;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      etsb_filter #(
        .MS_CYCLES (MS_CYCLES)
      ) u_filter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (event_input_pin[gi]),
        .tick    (r.tick),
        .setting (flt_set[gi]),
        .rise    (flt_rise[gi]),
        .fall    (flt_fall[gi])
      );
      // Capture gate and edge choice for this channel
      assign chan_hit[gi] = r.ev_en[gi] && r.cp_en[gi] && // R15
                            etsb_edge_hit(pol_sel[gi], flt_rise[gi], flt_fall[gi]); // R16
    end
  endgenerate

  always_comb begin
    logic [7:0]  widx;
    logic [7:0]  ridx;
    logic [31:0] rd;
    logic [31:0] wmask;
    logic [31:0] cap_data;
    logic [1:0]  ev_hit;
    logic        cap;
    logic        clr;
    widx = 8'h00;
    ridx = 8'h00;
    rd = 32'h0;
    wmask = 32'h0;
    cap_data = 32'h0;
    ev_hit = 2'h0;
    cap = 1'b0;
    clr = 1'b0;
    n = r;

    // Shared 125 ms sampling grid
    n.tick = 1'b0;
    if (r.grid_cnt + 32'h1 >= GRID_CYCLES) begin
      n.grid_cnt = 32'h0;
      n.tick = 1'b1; // R02
    end else begin
      n.grid_cnt = r.grid_cnt + 32'h1;
    end

    // Write channels, taken in either order
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (n.aw_got && n.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = etsb_mapped(n.awaddr) ? `ETSB_RESP_OKAY : `ETSB_RESP_SLVERR;
      widx = etsb_index(n.awaddr);
      wmask = etsb_strobe_mask(n.wstrb);
      if (etsb_mapped(n.awaddr) && n.wstrb[0]) begin
        case (widx)
          `ETSB_IDX_EV_EN: begin
            n.cp_en = {n.wdata[`ETSB_EN_CP2_BIT], n.wdata[`ETSB_EN_CP1_BIT]};
            n.ev_en = {n.wdata[`ETSB_EN_EV2_BIT], n.wdata[`ETSB_EN_EV1_BIT]};
          end
          `ETSB_IDX_EV1_CFG:  n.pol1 = n.wdata[1:0];
          `ETSB_IDX_EV2_CFG:  n.pol2 = n.wdata[1:0];
          `ETSB_IDX_FLT1:     n.flt1 = n.wdata[5:0]; // R01
          `ETSB_IDX_FLT2:     n.flt2 = n.wdata[5:0]; // R01
          `ETSB_IDX_BUF_CFG1: begin
            n.src_bin  = n.wdata[`ETSB_CFG1_SEL_BIT];
            n.ovw_mode = n.wdata[`ETSB_CFG1_OVW_BIT];
            n.full_ie  = n.wdata[`ETSB_CFG1_FIE_BIT];
            n.ne_ie    = n.wdata[`ETSB_CFG1_EIE_BIT];
            n.ovw_ie   = n.wdata[`ETSB_CFG1_OIE_BIT];
          end
          `ETSB_IDX_BUF_CFG2: n.sram = n.wdata[`ETSB_CFG2_SRAM_BIT]; // R13
          `ETSB_IDX_CMD_CFG:  n.clr_en = n.wdata[`ETSB_CMD_CLR_BIT];
          `ETSB_IDX_CMD_TRG:  clr = r.clr_en; // R12
          `ETSB_IDX_IRQ_STAT: n.irq_st = r.irq_st & ~n.wdata[2:0];
          `ETSB_IDX_IRQ_MASK: n.irq_mask = n.wdata[2:0];
          default: ;
        endcase
      end
      // Plain memory writes only in memory mode
      if (etsb_mapped(n.awaddr) && etsb_is_bank(widx) && r.sram) begin
        n.banks[widx[2:0]] = (r.banks[widx[2:0]] & ~wmask) | (n.wdata & wmask); // R13
      end
    end

    // Read channel; reads have no side effects
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      ridx = etsb_index(s_axi_araddr);
      if (etsb_mapped(s_axi_araddr)) begin
        rd = etsb_read_word(r, ridx);
        n.rresp = `ETSB_RESP_OKAY;
      end else begin
        n.rresp = `ETSB_RESP_SLVERR;
      end
      n.rdata = rd;
      n.rvalid = 1'b1;
    end

    // Flag clear by command trigger empties the buffer
    if (clr) begin
      n.full = 1'b0;
      n.empty = 1'b1;
      n.overwrite_flag = 1'b0;
      n.wr_ptr = 4'h0;
    end

    // Capture; both channels in one cycle give one capture
    ev_hit = chan_hit; // R15 R16
    cap = (|ev_hit) && !r.sram; // R13
    cap_data = r.src_bin ? bin_time_data : bcd_time_data; // R04
    if (cap) begin
      if (!n.full) begin
        n.banks[n.wr_ptr[2:0]] = cap_data; // R14
        if (n.empty) begin
          n.empty = 1'b0; // R10
          if (r.ne_ie) begin
            n.irq_st[`ETSB_IRQ_NE_BIT] = 1'b1; // R07
          end
        end
        if (n.wr_ptr[2:0] == `ETSB_LAST_BANK) begin
          n.full = 1'b1; // R09
          if (r.full_ie) begin
            n.irq_st[`ETSB_IRQ_FULL_BIT] = 1'b1; // R06
          end
        end
        n.wr_ptr = n.wr_ptr + 4'h1; // R14
      end else begin
        n.overwrite_flag = 1'b1; // R11
        if (r.ovw_ie) begin
          n.irq_st[`ETSB_IRQ_OVW_BIT] = 1'b1; // R08
        end
        if (r.ovw_mode) begin
          n.banks[`ETSB_LAST_BANK] = cap_data; // R05
        end
      end
    end

    // Ready and interrupt from next state
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.flt1 <= `ETSB_FLT_RST;
      r.flt2 <= `ETSB_FLT_RST;
      r.pol1 <= `ETSB_POL_RST;
      r.pol2 <= `ETSB_POL_RST;
      r.empty <= 1'(`ETSB_STAT_RST >> `ETSB_STAT_EMPTY_BIT); // R10
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign irq           = r.irq;

endmodule : etsb_top

// file: etsb_props.sv
`timescale 1ns/1ns
module etsb_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins and interrupt
  input wire logic [1:0]  event_input_pin,
  input wire logic        irq
);
  logic seen_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Any pin activity since reset
  always_ff @(posedge aclk) begin
    if (!aresetn) seen_r <= 1'b0;
    else if (event_input_pin != 2'h3) seen_r <= 1'b1;
  end

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write response not one cycle later");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle later");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_status_reset: assert property (!seen_r && s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h0A0 |=> s_axi_rdata == 32'h0000_0040) else $error("status not empty");
  a_irq_quiet: assert property (!seen_r |-> !irq)
    else $error("interrupt without any event");
endmodule : etsb_props

// file: etsb_event_src.sv
`timescale 1ns/1ns
module etsb_event_src (
  // Clock
  input wire logic       aclk,
  // Event pins, idle high
  output logic     [1:0] pin
);
  initial pin = 2'h3;

  // Low pulse of n cycles, then idle long enough for the filter to settle
  task automatic pulse(input int ch, input int n);
    @(posedge aclk) pin[ch] <= 1'b0;
    repeat (n) @(posedge aclk);
    pin[ch] <= 1'b1;
    repeat (n + 12) @(posedge aclk);
  endtask : pulse
endmodule : etsb_event_src

// file: tb.sv
`timescale 1ns/1ns
`include "etsb_regs.svh"
module tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, bcd, bin, rdat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, pins;
  int          bad_count, checks;

  etsb_top #(.GRID_CYCLES(40), .MS_CYCLES(8)) u_etsb_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_input_pin(pins), .bcd_time_data(bcd), .bin_time_data(bin), .irq(irq));

  etsb_event_src u_etsb_event_src (.aclk(aclk), .pin(pins));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rdat, exp);
  endtask : rc

  task automatic t_reset_vals();
    rc(8'h28, 32'h40);
    rc(8'h24, 32'h00);
    rc(8'h27, 32'h00);
    rc(8'h29, 32'h00);
    rd(8'h30);
    chk({30'h0, resp}, 32'h2);
    wr(8'h30, 32'h1);
    chk({30'h0, resp}, 32'h2);
    wr(8'h22, 32'hFF28);
    chk({30'h0, resp}, 32'h0);
    rc(8'h22, 32'h28);
    rc(8'h24, 32'h00);
    wr(8'h22, 32'h00);
  endtask : t_reset_vals

  task automatic t_fill();
    wr(8'h20, 32'h09);
    wr(8'h27, 32'h87);
    wr(8'h2D, 32'h07);
    for (int k = 0; k < 8; k++) begin
      bin <= 32'hB100_0000 + 32'(k);
      u_etsb_event_src.pulse(0, 20);
      if (k == 0) begin
        rc(8'h28, 32'h00);
        chk({31'h0, irq}, 32'h1);
        rc(8'h2C, 32'h02);
        wr(8'h2C, 32'h02);
      end
      if (k == 6) rc(8'h28, 32'h00);
    end
    rc(8'h28, 32'h80);
    rc(8'h2C, 32'h04);
    for (int k = 0; k < 8; k++) rc(8'h40 + 8'(k), 32'hB100_0000 + 32'(k));
    bin <= 32'hB200_0000;
    u_etsb_event_src.pulse(0, 20);
    rc(8'h28, 32'h81);
    rc(8'h2C, 32'h05);
    rc(8'h47, 32'hB100_0007);
    wr(8'h27, 32'hC7);
    bin <= 32'hB300_0000;
    u_etsb_event_src.pulse(0, 20);
    rc(8'h47, 32'hB300_0000);
    rc(8'h28, 32'h81);
    wr(8'h2A, 32'h01);
    wr(8'h2B, 32'h01);
    rc(8'h28, 32'h40);
    wr(8'h2C, 32'h07);
    rc(8'h2C, 32'h00);
    chk({31'h0, irq}, 32'h0);
  endtask : t_fill

  task automatic t_gate();
    wr(8'h20, 32'h08);
    u_etsb_event_src.pulse(0, 20);
    rc(8'h28, 32'h40);
  endtask : t_gate

  task automatic t_polarity();
    wr(8'h27, 32'h00);
    wr(8'h20, 32'h09);
    wr(8'h21, 32'h01);
    bcd <= 32'h0012_3456;
    u_etsb_event_src.pulse(0, 20);
    rc(8'h40, 32'h0012_3456);
    rc(8'h41, 32'hB100_0001);
    wr(8'h21, 32'h02);
    bcd <= 32'h0023_5959;
    u_etsb_event_src.pulse(0, 20);
    rc(8'h41, 32'h0023_5959);
    rc(8'h42, 32'h0023_5959);
    rc(8'h43, 32'hB100_0003);
    wr(8'h2B, 32'h01);
  endtask : t_polarity

  task automatic t_grid();
    wr(8'h24, 32'h02);
    wr(8'h20, 32'h12);
    bcd <= 32'h0031_1200;
    u_etsb_event_src.pulse(1, 15);
    rc(8'h28, 32'h40);
    u_etsb_event_src.pulse(1, 100);
    rc(8'h28, 32'h00);
    rc(8'h40, 32'h0031_1200);
  endtask : t_grid

  task automatic t_memory();
    wr(8'h29, 32'h40);
    wr(8'h44, 32'h5A5A_C3C3);
    rc(8'h44, 32'h5A5A_C3C3);
    wr(8'h20, 32'h1B);
    u_etsb_event_src.pulse(0, 20);
    rc(8'h28, 32'h00);
    rc(8'h41, 32'h0023_5959);
    wr(8'h29, 32'h00);
    wr(8'h45, 32'h0000_0001);
    rc(8'h45, 32'hB100_0005);
  endtask : t_memory

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs under two thousand cycles; allow about 20000
  initial begin
    #80000;
    bad_count++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 24'h0;
    {wdata, bcd, bin} = 96'h0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_vals();
    t_fill();
    t_gate();
    t_polarity();
    t_grid();
    t_memory();
    give_verdict();
  end
endmodule : tb

bind etsb_top etsb_props u_etsb_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .event_input_pin(event_input_pin), .irq(irq));
